/* File: rtl/lcd_ctrl_pkg.sv */
// constants and types shared by the dot-matrix lcd controller core
package lcd_ctrl_pkg;
	// serial frame: 4-bit opcode then 44-bit payload, lsb first
	localparam int FRAME_BITS = 48;
	localparam int OP_W = 4;
	localparam int PAY_W = 44;
	localparam logic [5:0] FRAME_LEN = 6'h30;
	localparam logic [3:0] OP_TECH = 4'h0;
	localparam logic [3:0] OP_DISP = 4'h1;
	localparam logic [3:0] OP_SHIFT = 4'h2;
	localparam logic [3:0] OP_ADDR = 4'h3;
	localparam logic [3:0] OP_WCHAR = 4'h4;
	localparam logic [3:0] OP_WSYM = 4'h5;
	localparam logic [3:0] OP_WUSER = 4'h6;
	localparam logic [3:0] OP_PORT = 4'h7;
	// payload field positions
	localparam int P_DUTY = 0;
	localparam int P_OSC = 1;
	localparam int P_M = 0;
	localparam int P_A = 1;
	localparam int P_SC = 2;
	localparam int P_DIR = 2;
	localparam int P_SYM_ADDR = 6;
	localparam int P_USER_PAT = 4;
	localparam int P_GP_VAL = 3;
	// memory and display geometry
	localparam int CHAR_DEPTH = 52;
	localparam int SYM_DEPTH = 13;
	localparam int DIGITS = 13;
	localparam int COLS = 5;
	localparam int PAT_W = 40;
	localparam int USER_DEPTH = 16;
	localparam int ROM_DEPTH = 240;
	localparam int KEY_LINES = 7;
	localparam int KEY_IN = 5;
	localparam int FIFO_DEPTH = 4;
	localparam logic [7:0] USER_CODE_LAST = 8'h0f;
	localparam logic [3:0] ROW_EXTRA8 = 4'h7;
	localparam logic [3:0] ROW_EXTRA9 = 4'h8;
	// timing
	localparam int CLK_NS = 40;
	localparam int EXEC_NS = 27000;
	localparam int EXEC_CYC = (EXEC_NS + CLK_NS - 1) / CLK_NS;
	localparam int ROW_NS = 10000;
	localparam int ROW_CYC = ROW_NS / CLK_NS;
	localparam int KEY_NS = 5000;
	localparam int KEY_CYC = KEY_NS / CLK_NS;

	typedef struct packed {
		logic [PAY_W-1:0] payload;
		logic [OP_W-1:0] opcode;
	} cmd_s;

	typedef enum logic {
		EX_IDLE = 1'b0,
		EX_WAIT = 1'b1
	} exec_e;
endpackage

/* File: rtl/lcd_ctrl_core.sv */
// lcd controller core: serial command intake, display memories, scan
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1 - inhibit low blanks display, ports low
// R2 - inhibit low clears key data, stops scan
// R3 - inhibit high enables display, scan, port config
// R4 - commands still accepted while inhibited
// R5 - pin 65 is segment or ninth common
// R6 - scan lines 1,2,7 switchable to outputs
// R7 - key sense inputs active high
// R8 - timing pin mode chosen by technique command
// R9 - host drives enable, clock, data; reads output
// R10 - one address counter for both rams; the code keeps separate counters ac_char and ac_sym
// R11 - char ram 52 x 8, 6-bit address
// R12 - digits 1..13 show addresses 00..0c
// R13 - char shift wraps modulo 52
// R14 - char address sent lsb first
// R15 - symbol ram 13 x 5, direct drive
// R16 - symbol shift wraps within 0..c
// R17 - symbol address sent lsb first
// R18 - pattern rom 240 x 40 by code
// R19 - written code shows its pattern
// R20 - user pattern ram 16 x 40
// R21 - sample on clock rise, latch on enable fall
// R22 - duty eight segment, duty nine common
// R23 - direction bit zero shifts left
// R24 - low sixteen codes select user patterns

////////////////////////////////////////////////////////////////////////
module cmd_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];

	// pointers wrap naturally; depth is a power of two
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // cmd_fifo

////////////////////////////////////////////////////////////////////////
module lcd_ctrl_core
	import lcd_ctrl_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic display_blank_n_i,
	input wire logic chip_enable_i,
	input wire logic serial_clock_i,
	input wire logic serial_in_i,
	input wire logic [KEY_IN-1:0] key_sense_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	output logic [63:0] segment_out_o,
	output logic seg_or_common_out_o,
	output logic [7:0] common_out_o,
	output logic [KEY_LINES-1:0] key_scan_drive_o,
	output logic [KEY_LINES*KEY_IN-1:0] key_data_o,
	output logic osc_ext_sel_o
);
	// wrap an offset into the 52-entry char space
	function automatic logic [5:0] char_at(logic [5:0] b, logic [5:0] d);
		logic [6:0] s;
		s = {1'b0, b} + {1'b0, d};
		return (s >= 7'h34) ? 6'(s - 7'h34) : s[5:0];
	endfunction
	// wrap an offset into the 13-entry symbol space
	function automatic logic [3:0] sym_at(logic [3:0] b, logic [3:0] d);
		logic [4:0] s;
		s = {1'b0, b} + {1'b0, d};
		return (s >= 5'h0d) ? 4'(s - 5'h0d) : s[3:0];
	endfunction
	// fixed glyph generator standing in for the mask rom contents
	function automatic logic [PAT_W-1:0] rom_pattern(logic [7:0] code);
		logic [7:0] idx;
		idx = code - 8'h10;
		return {idx, ~idx, idx, ~idx, idx};
	endfunction

	////////////////////////////////////////////////////////////////////
	// pin synchronisers: two stages; a third stage holds clock and enable for edge detection
	logic [8:0] sync1;
	logic [8:0] sync2;
	logic [1:0] sync3;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sync1 <= 9'h004;
			sync2 <= 9'h004;
			sync3 <= 2'h0;
		end else begin
			sync1 <= {key_sense_in_i, display_blank_n_i, serial_in_i,
				serial_clock_i, chip_enable_i};
			sync2 <= sync1;
			sync3 <= {sync2[1], sync2[0]};
		end
	end
	wire ce_s = sync2[0];
	wire din_s = sync2[2];
	wire inh_s = sync2[3];
	wire [KEY_IN-1:0] keys_s = sync2[8:4]; // R7
	wire sclk_rise = sync2[1] && !sync3[1];
	wire ce_fall = sync3[0] && !ce_s;
	wire blank = !inh_s; // R1 R3

	////////////////////////////////////////////////////////////////////
	// serial receiver; gathers bits regardless of inhibit
	logic [FRAME_BITS-1:0] shreg;
	logic [5:0] bit_cnt;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			shreg <= '0;
			bit_cnt <= '0;
		end else if (ce_fall) begin
			bit_cnt <= '0;
		end else if (ce_s && sclk_rise) begin
			shreg <= {din_s, shreg[FRAME_BITS-1:1]}; // R21 R14 R17
			bit_cnt <= (bit_cnt == 6'h3f) ? bit_cnt : bit_cnt + 6'h01;
		end
	end
	// frames of the wrong length are discarded at the latch point
	wire frame_push = ce_fall && (bit_cnt == FRAME_LEN); // R21 R4
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [FRAME_BITS-1:0] fifo_out_data;

	cmd_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_valid_i(frame_push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(shreg),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////
	// command executor: one command per execution time
	exec_e state;
	logic [9:0] exec_tmr;
	cmd_s cmd;
	assign cmd = cmd_s'(fifo_out_data);
	assign fifo_out_ready = (state == EX_IDLE);
	wire cmd_take = fifo_out_valid && fifo_out_ready;
	wire [PAY_W-1:0] pay = cmd.payload;
	wire is_shift = cmd_take && (cmd.opcode == OP_SHIFT);
	wire is_wchar = cmd_take && (cmd.opcode == OP_WCHAR);
	wire is_wsym = cmd_take && (cmd.opcode == OP_WSYM);
	wire is_wuser = cmd_take && (cmd.opcode == OP_WUSER);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= EX_IDLE;
			exec_tmr <= '0;
		end else begin
			case (state)
				EX_IDLE: begin
					if (cmd_take) begin
						state <= EX_WAIT;
						exec_tmr <= 10'(EXEC_CYC - 1);
					end
				end
				EX_WAIT: begin
					if (exec_tmr == '0) begin
						state <= EX_IDLE;
					end else begin
						exec_tmr <= exec_tmr - 10'h001;
					end
				end
				default: state <= EX_IDLE;
			endcase
		end
	end

	// configuration and address state
	logic duty9;
	logic osc_ext;
	logic m_on;
	logic a_on;
	logic sc_off;
	logic [5:0] char_off;
	logic [3:0] sym_off;
	logic [5:0] ac_char;
	logic [3:0] ac_sym;
	logic [2:0] gp_sel;
	logic [2:0] gp_val;
	logic [7:0] char_ram [0:CHAR_DEPTH-1]; // R11
	logic [COLS-1:0] sym_ram [0:SYM_DEPTH-1]; // R15
	logic [PAT_W-1:0] user_ram [0:USER_DEPTH-1]; // R20

	// shifted offsets: direction zero moves the window left
	wire [5:0] next_char_off = pay[P_DIR] ? char_at(char_off, 6'h33)
		: char_at(char_off, 6'h01); // R13 R23
	wire [3:0] next_sym_off = pay[P_DIR] ? sym_at(sym_off, 4'hc)
		: sym_at(sym_off, 4'h1); // R16 R23

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			duty9 <= 1'b0;
			osc_ext <= 1'b0;
			m_on <= 1'b0;
			a_on <= 1'b0;
			sc_off <= 1'b0;
			char_off <= '0;
			sym_off <= '0;
			ac_char <= '0;
			ac_sym <= '0;
			gp_sel <= '0;
			gp_val <= '0;
		end else if (cmd_take) begin
			case (cmd.opcode)
				OP_TECH: begin
					duty9 <= pay[P_DUTY]; // R5 R22
					osc_ext <= pay[P_OSC]; // R8
				end
				OP_DISP: begin
					m_on <= pay[P_M];
					a_on <= pay[P_A];
					sc_off <= pay[P_SC];
				end
				OP_SHIFT: begin
					char_off <= pay[P_M] ? next_char_off : char_off;
					sym_off <= pay[P_A] ? next_sym_off : sym_off;
				end
				OP_ADDR: begin
					ac_char <= (pay[5:0] < 6'h34) ? pay[5:0] : 6'h00; // R14
					ac_sym <= (pay[P_SYM_ADDR +: 4] < 4'hd)
						? pay[P_SYM_ADDR +: 4] : 4'h0; // R17
				end
				OP_WCHAR: ac_char <= char_at(ac_char, 6'h01); // R10
				OP_WSYM: ac_sym <= sym_at(ac_sym, 4'h1); // R10
				OP_PORT: begin
					gp_sel <= pay[2:0]; // R6
					gp_val <= pay[P_GP_VAL +: 3];
				end
				default: ;
			endcase
		end
	end

	// memory writes through the char and symbol address counters; user ram by payload address
	always_ff @(posedge clk_sys_i) begin
		if (is_wchar) begin
			char_ram[ac_char] <= pay[7:0]; // R10 R19
		end
		if (is_wsym) begin
			sym_ram[ac_sym] <= pay[COLS-1:0]; // R10
		end
		if (is_wuser) begin
			user_ram[pay[3:0]] <= pay[P_USER_PAT +: PAT_W]; // R20
		end
	end

	////////////////////////////////////////////////////////////////////
	// row scan: matrix rows, then one row for the extra symbols
	logic [3:0] row;
	logic [7:0] row_tmr;
	wire [3:0] row_extra = duty9 ? ROW_EXTRA9 : ROW_EXTRA8;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			row <= '0;
			row_tmr <= '0;
		end else if (row_tmr == 8'(ROW_CYC - 1)) begin
			row_tmr <= '0;
			row <= (row >= row_extra) ? 4'h0 : row + 4'h1;
		end else begin
			row_tmr <= row_tmr + 8'h01;
		end
	end

	// per-digit lookup; digit d shows base plus d
	logic [DIGITS*COLS-1:0] seg_row;
	genvar d;
	generate
		for (d = 0; d < DIGITS; d++) begin : g_digit
			wire [5:0] ca = char_at(char_off, 6'(d)); // R12 R13
			wire [3:0] sa = sym_at(sym_off, 4'(d)); // R16
			wire [7:0] code = char_ram[ca];
			wire use_user = (code <= USER_CODE_LAST); // R24
			wire [PAT_W-1:0] pat = use_user ? user_ram[code[3:0]]
				: rom_pattern(code); // R18 R19
			assign seg_row[d*COLS +: COLS] = (row == row_extra)
				? (a_on ? sym_ram[sa] : '0) // R15
				: (m_on ? pat[row*COLS +: COLS] : '0);
		end
	endgenerate

	wire drive_off = blank || sc_off; // R1
	wire [7:0] next_common = (drive_off || row > 4'h7) ? 8'h00
		: 8'(8'h01 << row);
	wire next_pin65 = drive_off ? 1'b0
		: (duty9 ? (row == ROW_EXTRA9) : seg_row[64]); // R5 R22
	wire [63:0] next_segment = drive_off ? 64'h0 : seg_row[63:0];

	////////////////////////////////////////////////////////////////////
	// key scan; lines 1, 2 and 7 may serve as plain outputs
	logic [2:0] ks_idx;
	logic [7:0] ks_tmr;
	logic [KEY_LINES*KEY_IN-1:0] key_data;
	wire [KEY_LINES-1:0] gp_mask = {gp_sel[2], 4'h0, gp_sel[1:0]}; // R6
	wire [KEY_LINES-1:0] gp_lvl = {gp_val[2], 4'h0, gp_val[1:0]};
	wire [KEY_LINES-1:0] scan_hot = 7'(7'h01 << ks_idx);
	wire [KEY_LINES-1:0] next_ks = blank ? '0
		: (gp_mask & gp_lvl) | (~gp_mask & scan_hot); // R1 R3 R6
	wire ks_step = (ks_tmr == 8'(KEY_CYC - 1));

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ks_idx <= '0;
			ks_tmr <= '0;
			key_data <= '0;
		end else if (blank) begin
			ks_tmr <= '0;
			key_data <= '0; // R2
		end else begin
			ks_tmr <= ks_step ? 8'h00 : ks_tmr + 8'h01;
			if (ks_step) begin
				// lines run as ports hold no keys; slot is still visited
				key_data[ks_idx*KEY_IN +: KEY_IN] <=
					gp_mask[ks_idx] ? '0 : keys_s; // R7 R3
				ks_idx <= (ks_idx == 3'h6) ? 3'h0 : ks_idx + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered outputs; data line pulled low while the queue is full
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			segment_out_o <= '0;
			seg_or_common_out_o <= 1'b0;
			common_out_o <= '0;
			key_scan_drive_o <= '0;
			key_data_o <= '0;
			osc_ext_sel_o <= 1'b0;
			serial_out_o <= 1'b0;
			serial_out_oe_o <= 1'b0;
		end else begin
			segment_out_o <= next_segment;
			seg_or_common_out_o <= next_pin65;
			common_out_o <= next_common;
			key_scan_drive_o <= next_ks;
			key_data_o <= blank ? '0 : key_data; // R2
			osc_ext_sel_o <= osc_ext; // R8
			serial_out_o <= 1'b0;
			serial_out_oe_o <= !fifo_in_ready; // R9
		end
	end

	////////////////////////////////////////////////////////////////////
	a_blank_drivers: assert property (@(posedge clk_sys_i) // R1
		disable iff (reset_i)
		blank |=> (segment_out_o == '0 && common_out_o == '0
			&& !seg_or_common_out_o))
		else $error("drivers not at low level while inhibited");
	a_blank_ports: assert property (@(posedge clk_sys_i) // R1
		disable iff (reset_i)
		blank |=> key_scan_drive_o == '0)
		else $error("scan lines not low while inhibited");
	a_key_clear: assert property (@(posedge clk_sys_i) // R2
		disable iff (reset_i)
		blank |=> (key_data_o == '0 && key_data == '0))
		else $error("key data kept while inhibited");
	a_frame_queued: assert property (@(posedge clk_sys_i) // R4
		disable iff (reset_i)
		frame_push && fifo_in_ready |=> fifo_out_valid)
		else $error("accepted frame not queued");
	a_char_wrap: assert property (@(posedge clk_sys_i) // R13
		disable iff (reset_i)
		is_shift && pay[P_M] && !pay[P_DIR] && char_off == 6'h33
		|=> char_off == 6'h00)
		else $error("char window did not wrap 33 to 00");
	a_sym_wrap: assert property (@(posedge clk_sys_i) // R16
		disable iff (reset_i)
		is_shift && pay[P_A] && pay[P_DIR] && sym_off == 4'h0
		|=> sym_off == 4'hc)
		else $error("symbol window did not wrap 0 to c");
	a_shift_left: assert property (@(posedge clk_sys_i) // R23
		disable iff (reset_i)
		is_shift && pay[P_M] && !pay[P_DIR] && char_off < 6'h33
		|=> char_off == $past(char_off) + 6'h01)
		else $error("left shift did not advance window");
	a_addr_step: assert property (@(posedge clk_sys_i) // R10
		disable iff (reset_i)
		is_wchar |=> ac_char == char_at($past(ac_char), 6'h01)
			&& ac_sym == $past(ac_sym))
		else $error("address counter did not step on write");
	a_pin65_common: assert property (@(posedge clk_sys_i) // R22
		disable iff (reset_i)
		duty9 && !drive_off
		|=> seg_or_common_out_o == ($past(row) == 4'h8))
		else $error("pin 65 not acting as ninth common");
	a_exec_gap: assert property (@(posedge clk_sys_i) // R21
		disable iff (reset_i)
		cmd_take |=> !cmd_take [*8])
		else $error("commands executed back to back");
endmodule // lcd_ctrl_core
`default_nettype wire

/* File: sim/host_model.sv */
// host controller model driving the serial command link of the lcd core
`timescale 1ns/1ns
`default_nettype none
module host_model
	import lcd_ctrl_pkg::*;
(
	input wire logic serial_line_i,
	output logic chip_enable_o,
	output logic serial_clock_o,
	output logic serial_data_o
);
	localparam int HALF_NS = 160;
	logic last_bit;
	logic busy_seen;

	////////////////////////////////////////////////////////////////////
	// idle: enable low, clock parked low, data line not left at last bit
	initial begin
		chip_enable_o = 1'b0;
		serial_clock_o = 1'b0;
		serial_data_o = 1'b1;
		last_bit = 1'b0;
		busy_seen = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// one whole frame; data moves only while the clock is low
	task automatic send(input cmd_s frame);
		logic [FRAME_BITS-1:0] bits;
		bits = frame;
		chip_enable_o = 1'b1;
		#(HALF_NS);
		for (int k = 0; k < FRAME_BITS; k++) begin
			serial_data_o = bits[k];
			last_bit = bits[k];
			#(HALF_NS);
			serial_clock_o = 1'b1;
			#(HALF_NS);
			serial_clock_o = 1'b0;
			if (serial_line_i === 1'b0) begin
				busy_seen = 1'b1;
			end
		end
		#(HALF_NS);
		chip_enable_o = 1'b0;
		serial_data_o = ~last_bit;
		// long enough low time so the core sees the enable fall
		#(4*HALF_NS);
	endtask
endmodule // host_model
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the lcd controller core
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import lcd_ctrl_pkg::*;
	localparam int LIMIT = 90000;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic display_blank_n_i = 1'b1;
	logic [KEY_IN-1:0] key_sense_in_i = '0;
	wire logic chip_enable, serial_clock, serial_data, serial_line;
	logic serial_out_o, serial_out_oe_o, seg_or_common_out_o, osc_ext_sel_o;
	logic [63:0] segment_out_o;
	logic [7:0] common_out_o;
	logic [KEY_LINES-1:0] key_scan_drive_o;
	logic [KEY_LINES*KEY_IN-1:0] key_data_o;
	int err_total = 0;
	int tests_run = 0;
	int cycles = 0;

	always #20 clk_sys_i = ~clk_sys_i;
	// open-drain line with a pull-up
	assign serial_line = serial_out_oe_o ? serial_out_o : 1'b1;

	lcd_ctrl_core uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.display_blank_n_i(display_blank_n_i),
		.chip_enable_i(chip_enable), .serial_clock_i(serial_clock),
		.serial_in_i(serial_data), .key_sense_in_i(key_sense_in_i),
		.serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
		.segment_out_o(segment_out_o),
		.seg_or_common_out_o(seg_or_common_out_o),
		.common_out_o(common_out_o), .key_scan_drive_o(key_scan_drive_o),
		.key_data_o(key_data_o), .osc_ext_sel_o(osc_ext_sel_o));
	host_model host (.serial_line_i(serial_line),
		.chip_enable_o(chip_enable), .serial_clock_o(serial_clock),
		.serial_data_o(serial_data));

	////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// cut a hang short
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			end_sim();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one frame, then the fixed execution time before the next
	task automatic cmd(input logic [3:0] op, input logic [43:0] p);
		cmd_s f;
		f.opcode = op;
		f.payload = p;
		host.send(f);
		repeat (EXEC_CYC + 20) @(negedge clk_sys_i);
	endtask

	// bounded wait for the start of a given row, then settle inside it
	task automatic wait_row(input logic [7:0] row);
		int n;
		n = 0;
		// leave the row first, so a row about to end is never taken
		while (common_out_o === row && n < 300) begin
			@(negedge clk_sys_i);
			n++;
		end
		while (common_out_o !== row && n < 2600) begin
			@(negedge clk_sys_i);
			n++;
		end
		repeat (2) @(negedge clk_sys_i);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic test_display();
		cmd(OP_WUSER, {40'h00_0000_0013, 4'h1});
		cmd(OP_ADDR, 44'h280);
		cmd(OP_WCHAR, 44'h01);
		cmd(OP_WCHAR, 44'h15);
		cmd(OP_WSYM, 44'h1b);
		cmd(OP_DISP, 44'h3);
		wait_row(8'h01);
		check(64'(segment_out_o[4:0]), 64'h13);
		check(64'(segment_out_o[9:5]), 64'h05);
		wait_row(8'h80);
		check(64'(segment_out_o[54:50]), 64'h1b);
		$display("test display done");
	endtask

	task automatic test_shift();
		cmd(OP_SHIFT, 44'h3);
		wait_row(8'h01);
		check(64'(segment_out_o[4:0]), 64'h05);
		wait_row(8'h80);
		check(64'(segment_out_o[49:45]), 64'h1b);
		// two right shifts of both: bases wrap to 33 and to c
		cmd(OP_SHIFT, 44'h7);
		cmd(OP_SHIFT, 44'h7);
		wait_row(8'h01);
		check(64'(segment_out_o[9:5]), 64'h13);
		wait_row(8'h80);
		check(64'(segment_out_o[59:55]), 64'h1b);
		// left shift of the matrix from 33 wraps back to 00
		cmd(OP_SHIFT, 44'h1);
		wait_row(8'h01);
		check(64'(segment_out_o[4:0]), 64'h13);
		$display("test shift done");
	endtask

	task automatic test_keys();
		@(negedge clk_sys_i);
		key_sense_in_i = 5'h05;
		repeat (8*KEY_CYC + 10) @(negedge clk_sys_i);
		check(64'(key_data_o), 64'({7{5'h05}}));
		$display("test keys done");
	endtask

	task automatic test_inhibit();
		@(negedge clk_sys_i);
		display_blank_n_i = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		check(segment_out_o, 64'h0);
		check(64'({seg_or_common_out_o, common_out_o}), 64'h0);
		check(64'(key_data_o), 64'h0);
		// port setup sent while blanked must still be taken
		cmd(OP_PORT, 44'h2f);
		check(64'(key_scan_drive_o), 64'h0);
		check(64'(key_data_o), 64'h0);
		display_blank_n_i = 1'b1;
		repeat (8*KEY_CYC + 10) @(negedge clk_sys_i);
		check(64'(key_scan_drive_o & 7'h43), 64'h41);
		check(64'(key_data_o[4:0]), 64'h0);
		check(64'(key_data_o[14:10]), 64'h05);
		$display("test inhibit done");
	endtask

	task automatic test_busy();
		cmd_s f;
		f.opcode = OP_SHIFT;
		f.payload = '0;
		host.busy_seen = 1'b0;
		// frames arrive faster than they execute, so the queue fills
		for (int i = 0; i < 16; i++) begin
			host.send(f);
		end
		check(64'(host.busy_seen), 64'h1);
		repeat (5*EXEC_CYC) @(negedge clk_sys_i);
		check(64'(serial_line), 64'h1);
		$display("test busy done");
	endtask

	task automatic test_technique();
		int n;
		n = 0;
		cmd(OP_TECH, 44'h3);
		check(64'(osc_ext_sel_o), 64'h1);
		while (seg_or_common_out_o !== 1'b1 && n < 2600) begin
			@(negedge clk_sys_i);
			n++;
		end
		check(64'(seg_or_common_out_o), 64'h1);
		check(64'(common_out_o), 64'h0);
		$display("test technique done");
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge clk_sys_i);
		reset_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		check(64'(serial_out_oe_o), 64'h0);
		test_display();
		test_shift();
		test_keys();
		test_inhibit();
		test_busy();
		test_technique();
		end_sim();
	end
endmodule // testbench
`default_nettype wire
